//--- hw/lincsr_pkg.sv
package lincsr_pkg;

   // Indirect core register locations
   localparam logic [7:0] LINCSR_ADDR_DATA8  = 8'h07;
   localparam logic [7:0] LINCSR_ADDR_CTRL   = 8'h08;
   localparam logic [7:0] LINCSR_ADDR_STATUS = 8'h09;
   localparam logic [7:0] LINCSR_ADDR_FAULT  = 8'h0A;
   localparam logic [7:0] LINCSR_ADDR_SIZE   = 8'h0B;
   localparam logic [7:0] LINCSR_ADDR_DIVLO  = 8'h0C;
   localparam logic [7:0] LINCSR_ADDR_SCALE  = 8'h0D;

   // Control bit positions
   localparam int LINCSR_CTL_HALT   = 7;
   localparam int LINCSR_CTL_DORM   = 6;
   localparam int LINCSR_CTL_DIR    = 5;
   localparam int LINCSR_CTL_ACK    = 4;
   localparam int LINCSR_CTL_CLRIRQ = 3;
   localparam int LINCSR_CTL_CLRERR = 2;
   localparam int LINCSR_CTL_WAKE   = 1;
   localparam int LINCSR_CTL_GO     = 0;

   // Status bit positions
   localparam int LINCSR_ST_ACTIVE = 7;
   localparam int LINCSR_ST_IDLE   = 6;
   localparam int LINCSR_ST_CUT    = 5;
   localparam int LINCSR_ST_IDRX   = 4;
   localparam int LINCSR_ST_IRQ    = 3;
   localparam int LINCSR_ST_FAULT  = 2;
   localparam int LINCSR_ST_WAKE   = 1;
   localparam int LINCSR_ST_DONE   = 0;

   // Fault detail positions
   localparam int LINCSR_FD_SYNC   = 4;
   localparam int LINCSR_FD_PARITY = 3;
   localparam int LINCSR_FD_TIMEOUT_FAULT   = 2;
   localparam int LINCSR_FD_CHK    = 1;
   localparam int LINCSR_FD_BIT    = 0;

   // Size register fields
   localparam int         LINCSR_SZ_ENH     = 7;
   localparam logic [3:0] LINCSR_SZ_MAX     = 4'h8;
   localparam logic [3:0] LINCSR_SZ_FROM_ID = 4'hF;

   // Reset values
   localparam logic [7:0] LINCSR_RST_BYTE = 8'h00;

   // Divider limits
   localparam logic [8:0] LINCSR_DIV_MIN = 9'd200;
   localparam logic [8:0] LINCSR_DIV_MAX = 9'd511;

   // Idle time for slave timeout
   localparam longint LINCSR_IDLE_MS   = 4000;
   localparam longint LINCSR_CLK_HZ    = 100_000_000;
   localparam longint LINCSR_IDLE_CYC  = LINCSR_IDLE_MS * (LINCSR_CLK_HZ / 1000);

endpackage : lincsr_pkg

//--- hw/lincsr_core.sv
module lincsr_core
   import lincsr_pkg::*;
#(
   parameter longint IDLE_CYC = LINCSR_IDLE_CYC   // Idle timeout, shorten in sim
) (
   // Clock and reset
   input  wire logic       i_core_clk,     // System clock
   input  wire logic       i_rst,          // Async reset, high

   // Register window, pointer and data
   input  wire logic [7:0] i_ptr,          // Core pointer value
   input  wire logic       i_win_wr,       // Window write strobe
   input  wire logic       i_win_rd,       // Window read strobe
   input  wire logic [7:0] i_win_wdata,    // Window write data
   output logic      [7:0] o_win_rdata,    // Window read data

   // Role and identifier
   input  wire logic       i_master_mode,  // 1 master, 0 slave
   input  wire logic [5:0] i_frame_tag,    // Identifier bits

   // Engine levels and one-cycle event pulses
   input  wire logic       i_bus_active,   // Engine sees bus activity
   input  wire logic       i_bus_asleep,   // Bus in sleep
   input  wire logic       i_break_seen,   // Sync break detected pulse
   input  wire logic       i_frame_start,  // Frame start pulse
   input  wire logic       i_frame_end,    // Frame finished pulse
   input  wire logic       i_id_rx,        // Identifier received pulse
   input  wire logic       i_wake_rx,      // Wakeup received pulse
   input  wire logic       i_wake_sent,    // Wakeup transmission over pulse
   input  wire logic       i_rx_byte_wr,   // Engine stores received byte 8
   input  wire logic [7:0] i_rx_byte,      // Received byte 8
   input  wire logic [4:0] i_fault_evt,    // Fault pulses, fault-detail layout
   input  wire logic       i_first_byte_end, // First byte after identifier ended

   // Control levels for the engine
   output logic            o_frame_go,     // Master frame start request
   output logic            o_wake_tx,      // Sending wakeup
   output logic            o_halted,       // Ignoring traffic until break
   output logic            o_tx_dir,       // 1 transmit frame
   output logic            o_ack,          // Data request acknowledged
   output logic            o_dormant,      // Software sleep warning

   // Frame format, baud fields, data and interrupt
   output logic            o_enh_sum,      // Enhanced checksum
   output logic      [3:0] o_payload_len,  // Resolved byte count
   output logic            o_len_reserved, // Reserved length code
   output logic      [8:0] o_divisor,      // Baud divider
   output logic            o_div_ok,       // Divider in valid range
   output logic      [1:0] o_prescale,     // Baud prescaler
   output logic      [4:0] o_multiply,     // Baud multiplier, master only
   output logic      [7:0] o_tx_byte,      // Byte 8 to send
   output logic            o_irq           // Interrupt request
);

   ////////////////////////////////////////////////////////////////////////////
   // State

   typedef struct packed {
      logic [7:0]  data8;
      logic        halted;
      logic        dormant;
      logic        dir;
      logic        ack;
      logic        wake;
      logic        go;
      logic        cut;
      logic        idrx;
      logic        irq;
      logic        fault;
      logic        wake_seen;
      logic        done;
      logic        idle;
      logic [4:0]  fd;
      logic        enh;
      logic [3:0]  len;
      logic [7:0]  div_lo;
      logic [7:0]  scale;
      logic [31:0] idle_cnt;
      logic        in_frame;
      logic [7:0]  rdata;
   } lincsr_state_t;

   lincsr_state_t st;
   lincsr_state_t next_st;

   // Field notes for the state word:
   //   data8     eighth payload byte, shared by software and the engine
   //   halted    slave ignores traffic until the engine reports a break
   //   dormant   software sleep warning, passed straight to the engine
   //   dir       frame direction, 0 receive and 1 transmit
   //   ack       slave data request acknowledge, cleared by hardware
   //   wake      wakeup request, held until the engine reports it sent
   //   go        master start request, held until frame end or fault
   //   cut       slave frame cut short by break or halt
   //   idrx      slave identifier seen since the last break
   //   irq       pending interrupt, sticky until software clears it
   //   fault     any error seen, sticky until the error clear
   //   wake_seen wakeup sent or received since the last frame start
   //   done      last frame finished
   //   idle      slave bus idle timeout reached
   //   fd        sticky fault detail bits in read layout
   //   enh, len  checksum style and raw length code
   //   div_lo    low eight divider bits
   //   scale     prescaler, multiplier and divider top bit
   //   idle_cnt  quiet cycles counted toward the idle flag
   //   in_frame  a frame has started and not yet ended
   //   rdata     registered window read data

   // Resolve byte count from length code and identifier
   // Codes 9 to 14 pass through unchanged; o_len_reserved flags them
   // so the engine can refuse the frame instead of guessing a size.
   function automatic logic [3:0] lincsr_len(input logic [3:0] code,
                                             input logic [1:0] tag);
      logic [3:0] r;
      r = code;
      if (code == LINCSR_SZ_FROM_ID) begin
         unique case (tag)
            2'b10:   r = 4'h4;
            2'b11:   r = 4'h8;
            default: r = 4'h2;
         endcase
      end
      return r;
   endfunction : lincsr_len

   logic       slave;
   logic       wr_ctl;
   logic [4:0] fault_in;
   logic       timeout_fault_ack;
   logic [7:0] ctl_rd;
   logic [7:0] st_rd;
   logic       any_evt;

   ////////////////////////////////////////////////////////////////////////////
   // Next state
   // Order matters below: each later block may override an earlier one.
   //   1. Frame tracking and engine writes
   //   2. Break handling, then identifier receipt
   //   3. Software control writes, which may set or clear
   //   4. Fault, idle and wake tracking
   //   5. Sticky set events last, so a racing clear never loses an event
   //   6. Window read data, captured only on a read strobe
   // Every engine pulse lasts one cycle and takes effect at the next edge.
   // Software writes land at the edge that samples the write strobe,
   // and the new value is visible on the outputs right after that same edge.
   always_comb begin
      next_st  = st;
      slave    = ~i_master_mode;
      wr_ctl   = i_win_wr && (i_ptr == LINCSR_ADDR_CTRL);
      // Late ack: slave gave neither ack nor halt by the first data byte
      timeout_fault_ack = slave && i_first_byte_end && !st.ack && !st.halted;
      fault_in = i_fault_evt;
      fault_in[LINCSR_FD_TIMEOUT_FAULT] = i_fault_evt[LINCSR_FD_TIMEOUT_FAULT] | timeout_fault_ack;
      if (!slave) begin
         fault_in[LINCSR_FD_SYNC]   = 1'b0;
         fault_in[LINCSR_FD_PARITY] = 1'b0;
      end

      // Frame tracking
      // A start and an end in one cycle leave the frame closed and done,
      // since the end is applied second.
      if (i_frame_start) begin
         next_st.in_frame = 1'b1;
         next_st.done     = 1'b0;
      end
      if (i_frame_end) begin
         next_st.in_frame = 1'b0;
         next_st.done     = 1'b1;
         next_st.go       = 1'b0;
         next_st.ack      = 1'b0;
      end

      // Engine stores received byte, else software write
      if (i_win_wr && i_ptr == LINCSR_ADDR_DATA8) begin
         next_st.data8 = i_win_wdata;
      end
      if (i_rx_byte_wr && !st.dir) begin
         next_st.data8 = i_rx_byte;
      end

      // Self-clearing wake request ends when pulse is out
      if (i_wake_sent) begin
         next_st.wake = 1'b0;
      end

      // Halt lasts until the next sync break
      // The break also forgets any identifier and acknowledge, so a slave
      // that missed the frame starts clean on the next one.
      if (i_break_seen && slave) begin
         next_st.halted = 1'b0;
         next_st.cut    = st.in_frame;
         next_st.idrx   = 1'b0;
         next_st.ack    = 1'b0;
         next_st.in_frame = 1'b0;
      end
      if (i_id_rx && slave && !st.halted) begin
         next_st.idrx = 1'b1;
      end

      // Control writes; set events below still win over clears
      if (wr_ctl) begin
         next_st.dormant = i_win_wdata[LINCSR_CTL_DORM];
         next_st.dir     = i_win_wdata[LINCSR_CTL_DIR];
         if (slave && i_win_wdata[LINCSR_CTL_HALT]) begin
            next_st.halted = 1'b1;
            next_st.cut    = 1'b1;
         end
         if (slave && i_win_wdata[LINCSR_CTL_ACK]) begin
            next_st.ack = 1'b1;
         end
         if (i_win_wdata[LINCSR_CTL_WAKE]) begin
            next_st.wake = 1'b1;
         end
         if (!slave && i_win_wdata[LINCSR_CTL_GO]) begin
            next_st.go = 1'b1;
         end
         if (i_win_wdata[LINCSR_CTL_CLRIRQ]) begin
            next_st.irq = 1'b0;
         end
         if (i_win_wdata[LINCSR_CTL_CLRERR]) begin
            next_st.fault = 1'b0;
            next_st.fd    = '0;
         end
      end

      // Go drops on any error; it is the master's start request
      if (|fault_in) begin
         next_st.go = 1'b0;
      end

      // Idle counter runs in slave mode while the bus is quiet
      // The count restarts on any activity, on sleep and in master mode;
      // the flag then holds until one of those ends the quiet spell.
      // At the default of four seconds the counter needs 29 bits.
      if (!slave || i_bus_active || i_bus_asleep) begin
         next_st.idle_cnt = '0;
         next_st.idle     = 1'b0;
      end else if (st.idle_cnt >= 32'(IDLE_CYC - 1)) begin
         next_st.idle = 1'b1;
      end else begin
         next_st.idle_cnt = st.idle_cnt + 32'd1;
      end

      // Wake seen while sending or once received
      if (st.wake || i_wake_rx) begin
         next_st.wake_seen = 1'b1;
      end else if (i_frame_start) begin
         next_st.wake_seen = 1'b0;
      end

      // Sticky error bits; set wins over the clear above
      // Parity and sync faults were masked above in master mode, so the
      // detail register only records what this role can detect.
      next_st.fd = next_st.fd | fault_in;
      if (|fault_in) begin
         next_st.fault = 1'b1;
      end

      // Interrupt sources, set wins over clear
      any_evt = i_frame_end || (|fault_in) || (i_id_rx && slave && !st.halted)
                || i_wake_rx || i_wake_sent || (next_st.idle && !st.idle);
      if (any_evt) begin
         next_st.irq = 1'b1;
      end

      // Size and baud registers
      if (i_win_wr && i_ptr == LINCSR_ADDR_SIZE) begin
         next_st.enh = i_win_wdata[LINCSR_SZ_ENH];
         next_st.len = i_win_wdata[3:0];
      end
      if (i_win_wr && i_ptr == LINCSR_ADDR_DIVLO) begin
         next_st.div_lo = i_win_wdata;
      end
      if (i_win_wr && i_ptr == LINCSR_ADDR_SCALE) begin
         next_st.scale = i_win_wdata;
      end

      // Read view; clear-type bits always read 0
      // Bus activity is read live, the rest from registers; the read data
      // stays in place until the next read strobe, so a slow master
      // can take it later.
      ctl_rd = {1'b0, st.dormant, st.dir, st.ack, 1'b0, 1'b0, st.wake, st.go};
      st_rd  = {i_bus_active, st.idle, st.cut, st.idrx,
                st.irq, st.fault, st.wake_seen, st.done};
      if (i_win_rd) begin
         unique case (i_ptr)
            LINCSR_ADDR_DATA8:  next_st.rdata = st.data8;
            LINCSR_ADDR_CTRL:   next_st.rdata = ctl_rd;
            LINCSR_ADDR_STATUS: next_st.rdata = st_rd;
            LINCSR_ADDR_FAULT:  next_st.rdata = {3'b000, st.fd};
            LINCSR_ADDR_SIZE:   next_st.rdata = {st.enh, 3'b000, st.len};
            LINCSR_ADDR_DIVLO:  next_st.rdata = st.div_lo;
            LINCSR_ADDR_SCALE:  next_st.rdata = st.scale;
            default:            next_st.rdata = LINCSR_RST_BYTE;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Register
   always_ff @(posedge i_core_clk or posedge i_rst) begin
      if (i_rst) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Outputs; divider range is software's duty, flagged for the engine
   assign o_win_rdata    = st.rdata;

   // Control levels for the engine
   assign o_frame_go     = st.go;
   assign o_wake_tx      = st.wake;
   assign o_halted       = st.halted;
   assign o_tx_dir       = st.dir;
   assign o_ack          = st.ack;
   assign o_dormant      = st.dormant;

   // Frame format
   assign o_enh_sum      = st.enh;
   assign o_payload_len  = lincsr_len(st.len, i_frame_tag[5:4]);
   assign o_len_reserved = (st.len > LINCSR_SZ_MAX) && (st.len != LINCSR_SZ_FROM_ID);

   // Baud fields
   assign o_divisor      = {st.scale[0], st.div_lo};
   assign o_div_ok       = (o_divisor >= LINCSR_DIV_MIN) && (o_divisor <= LINCSR_DIV_MAX);
   assign o_prescale     = st.scale[7:6];
   assign o_multiply     = i_master_mode ? st.scale[5:1] : 5'h00;

   // Data and interrupt
   assign o_tx_byte      = st.data8;
   assign o_irq          = st.irq;

   // Limitations worth knowing:
   //   The idle counter is 32 bits wide, so IDLE_CYC must stay below 2**32.
   //   Pointer values outside the seven core registers read 0, ignore writes.
   //   Writes to status and fault detail are ignored; only clear bits act.
   //   Divider range is not enforced; the engine sees o_div_ok instead,
   //   which trades a silent clamp for a visible flag.
   //   Set events win over a software clear landing in the same cycle,
   //   so no interrupt or error is lost to a racing clear.
   //   Multiplier reads back as written even in slave mode.

endmodule : lincsr_core

//--- verif/lincsr_core_asserts.sv
module lincsr_core_asserts
   import lincsr_pkg::*;
(
   input wire logic       i_core_clk,    // Clock
   input wire logic       i_rst,         // Async reset
   input wire logic [7:0] i_ptr,         // Pointer
   input wire logic       i_win_wr,      // Write strobe
   input wire logic       i_win_rd,      // Read strobe
   input wire logic [7:0] i_win_wdata,   // Write data
   input wire logic [7:0] o_win_rdata,   // Read data
   input wire logic       i_master_mode, // Role
   input wire logic       i_break_seen,  // Break pulse
   input wire logic       i_frame_end,   // End pulse
   input wire logic       i_wake_sent,   // Wake done pulse
   input wire logic [4:0] i_fault_evt,   // Fault pulses
   input wire logic       o_frame_go,    // Start request
   input wire logic       o_wake_tx,     // Sending wake
   input wire logic       o_halted,      // Halted
   input wire logic       o_tx_dir,      // Direction
   input wire logic       o_ack,         // Ack
   input wire logic [8:0] o_divisor,     // Divider
   input wire logic       o_div_ok,      // Divider valid
   input wire logic       o_irq          // Interrupt
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking cb @(posedge i_core_clk); endclocking
   default disable iff (i_rst);

   ////////////////////////////////////////////////////////////////////////////////
   // Control writes; a write in the same cycle may set a bit again, so it is excluded
   logic ctl_wr;
   logic dir_bit;
   assign ctl_wr  = i_win_wr && (i_ptr == LINCSR_ADDR_CTRL);
   assign dir_bit = i_win_wdata[LINCSR_CTL_DIR];

   ////////////////////////////////////////////////////////////////////////////////
   a_go_ends_frame: assert property (o_frame_go && i_frame_end && !ctl_wr
      |=> !o_frame_go) else $error("start request stayed after frame end");
   a_wake_clears: assert property (o_wake_tx && i_wake_sent && !ctl_wr
      |=> !o_wake_tx) else $error("wake request stayed after wake sent");
   a_go_master_only: assert property ($rose(o_frame_go)
      |-> $past(i_master_mode)) else $error("start request raised in slave mode");
   a_irq_holds: assert property (o_irq && !(ctl_wr && i_win_wdata[LINCSR_CTL_CLRIRQ])
      |=> o_irq) else $error("interrupt dropped without clear");
   a_end_raises_irq: assert property (i_frame_end |=> o_irq)
      else $error("frame end raised no interrupt");
   a_fault_raises_irq: assert property (|i_fault_evt[2:0] |=> o_irq)
      else $error("fault raised no interrupt");
   a_halt_in_slave: assert property (ctl_wr && !i_master_mode && i_win_wdata[7]
      && !i_break_seen |=> o_halted) else $error("halt write not taken");
   a_ack_auto_clear: assert property (o_ack && (i_frame_end || i_break_seen) && !ctl_wr
      |=> !o_ack) else $error("ack not cleared");
   a_dir_follows: assert property (ctl_wr |=> o_tx_dir == $past(dir_bit))
      else $error("direction not written");
   a_div_window: assert property (o_div_ok == (o_divisor >= LINCSR_DIV_MIN))
      else $error("divider range flag wrong");
   a_fault_upper_zero: assert property (i_win_rd && i_ptr == LINCSR_ADDR_FAULT
      |=> o_win_rdata[7:5] == 3'h0) else $error("fault detail upper bits set");

   c_frame: cover property (o_frame_go ##[1:20] i_frame_end);
   c_halt: cover property (o_halted);
   c_wake: cover property (o_wake_tx ##[1:10] !o_wake_tx);
endmodule : lincsr_core_asserts

//--- verif/lincsr_node_model.sv
module lincsr_node_model (
   input  wire logic i_core_clk,    // Clock
   input  wire logic i_rst,         // Async reset
   input  wire logic i_frame_go,    // Start request from core
   input  wire logic i_wake_tx,     // Wake request from core
   output logic      o_frame_start, // Frame start pulse
   output logic      o_frame_end,   // Frame end pulse
   output logic      o_bus_active,  // Bus activity level
   output logic      o_wake_sent    // Wake finished pulse
);
   timeunit 1ns;
   timeprecision 1ps;
   localparam int FRAME_LEN = 8;
   localparam int WAKE_LEN  = 6;
   int fcnt;
   int wcnt;

   ////////////////////////////////////////////////////////////////////////////////
   // Frame runs only once per request; count waits for go to drop before rearming
   always_ff @(posedge i_core_clk or posedge i_rst) begin
      if (i_rst) begin
         {o_frame_start, o_frame_end, o_bus_active, o_wake_sent} <= 4'h0;
         fcnt <= 0;
         wcnt <= 0;
      end else begin
         o_frame_start <= 1'b0;
         o_frame_end   <= 1'b0;
         o_wake_sent   <= 1'b0;
         if (i_frame_go && !o_bus_active && fcnt == 0) begin
            o_frame_start <= 1'b1;
            o_bus_active  <= 1'b1;
            fcnt          <= 1;
         end else if (o_bus_active) begin
            fcnt <= fcnt + 1;
            if (fcnt == FRAME_LEN) begin
               o_frame_end  <= 1'b1;
               o_bus_active <= 1'b0;
            end
         end else if (!i_frame_go) begin
            fcnt <= 0;
         end
         // Wakeup signal lasts a few cycles, then reports done
         if (i_wake_tx && wcnt < WAKE_LEN) begin
            wcnt <= wcnt + 1;
         end else if (i_wake_tx) begin
            o_wake_sent <= 1'b1;
            wcnt        <= 0;
         end
      end
   end
endmodule : lincsr_node_model

//--- verif/lincsr_core_test.sv
module lincsr_core_test;
   timeunit 1ns;
   timeprecision 1ps;
   import lincsr_pkg::*;
   localparam longint IDLE = 50;
   logic clk = 1'b0, rst = 1'b1, wr = 1'b0, rd = 1'b0, mm = 1'b0;
   logic [7:0] ptr = 8'h00, wd = 8'h00, rxb = 8'h00, rdat, txb;
   logic [5:0] tag = 6'h00;
   logic [6:0] ev = 7'h00;
   logic [4:0] fe = 5'h00, mul;
   logic go, wtx, halt, dir, ack, dorm, enh, lres, dok, irq;
   logic [3:0] len;
   logic [8:0] div;
   logic [1:0] pre;
   logic p_start, p_end, p_act, p_wsent;
   logic [3:0] lut [4] = '{4'h2, 4'h2, 4'h4, 4'h8};
   int fail_count = 0, checks_done = 0, a;

   always #5 clk = ~clk;

   lincsr_core #(.IDLE_CYC(IDLE)) dut (.i_core_clk(clk), .i_rst(rst), .i_ptr(ptr),
      .i_win_wr(wr), .i_win_rd(rd), .i_win_wdata(wd), .o_win_rdata(rdat), .i_master_mode(mm),
      .i_frame_tag(tag), .i_bus_active(p_act), .i_bus_asleep(1'b0), .i_break_seen(ev[0]),
      .i_frame_start(ev[1] | p_start), .i_frame_end(ev[2] | p_end), .i_id_rx(ev[3]),
      .i_wake_rx(ev[4]), .i_wake_sent(p_wsent), .i_rx_byte_wr(ev[6]), .i_rx_byte(rxb),
      .i_fault_evt(fe), .i_first_byte_end(ev[5]), .o_frame_go(go), .o_wake_tx(wtx),
      .o_halted(halt), .o_tx_dir(dir), .o_ack(ack), .o_dormant(dorm), .o_enh_sum(enh),
      .o_payload_len(len), .o_len_reserved(lres), .o_divisor(div), .o_div_ok(dok),
      .o_prescale(pre), .o_multiply(mul), .o_tx_byte(txb), .o_irq(irq));
   lincsr_node_model node (.i_core_clk(clk), .i_rst(rst), .i_frame_go(go), .i_wake_tx(wtx),
      .o_frame_start(p_start), .o_frame_end(p_end), .o_bus_active(p_act), .o_wake_sent(p_wsent));

   ////////////////////////////////////////////////////////////////////////////////
   // Window access: one strobe cycle, read data sampled one cycle later
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      checks_done++;
      if (got !== exp) begin
         fail_count++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk
   task automatic wr_reg(input logic [7:0] ad, input logic [7:0] d);
      @(negedge clk); ptr = ad; wd = d; wr = 1'b1;
      @(negedge clk); wr = 1'b0;
   endtask : wr_reg
   task automatic rd_reg(input logic [7:0] ad, input logic [7:0] e, input logic [7:0] m);
      @(negedge clk); ptr = ad; rd = 1'b1;
      @(negedge clk); rd = 0;
      chk(rdat & m, e & m);
   endtask : rd_reg
   task automatic pulse(input logic [6:0] m);
      @(negedge clk); ev = m;
      @(negedge clk); ev = 7'h00;
   endtask : pulse
   task automatic wrap_up;
      $display("checks %0d mismatches %0d", checks_done, fail_count);
      if (fail_count == 0 && checks_done > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask : wrap_up

   ////////////////////////////////////////////////////////////////////////////////
   // Tests: reset state, data byte, frames, faults, slave controls, fields
   initial begin
      repeat (10) @(posedge clk);
      @(negedge clk); rst = 1'b0;
      for (a = 7; a <= 13; a++) rd_reg(a[7:0], 8'h00, 8'hFF);
      rd_reg(8'h20, 8'h00, 8'hFF);
      repeat (IDLE) @(negedge clk);
      rd_reg(LINCSR_ADDR_STATUS, 8'h48, 8'h48);
      wr_reg(LINCSR_ADDR_CTRL, 8'h08);
      $display("test reset_idle done");
      wr_reg(LINCSR_ADDR_DATA8, 8'hA5); rd_reg(LINCSR_ADDR_DATA8, 8'hA5, 8'hFF);
      chk(txb, 8'hA5);
      wr_reg(LINCSR_ADDR_CTRL, 8'h00); rxb = 8'h3C; pulse(7'h40);
      rd_reg(LINCSR_ADDR_DATA8, 8'h3C, 8'hFF);
      wr_reg(LINCSR_ADDR_CTRL, 8'h20); rd_reg(LINCSR_ADDR_CTRL, 8'h20, 8'hFF);
      chk(dir, 1'b1);
      $display("test data_byte done");
      mm = 1'b1; wr_reg(LINCSR_ADDR_CTRL, 8'h01); chk(go, 1'b1);
      rd_reg(LINCSR_ADDR_STATUS, 8'h80, 8'h81);
      for (a = 0; a < 40 && go; a++) @(negedge clk);
      chk(go, 1'b0);
      rd_reg(LINCSR_ADDR_STATUS, 8'h09, 8'hFF);
      chk(irq, 1'b1);
      wr_reg(LINCSR_ADDR_CTRL, 8'h08); rd_reg(LINCSR_ADDR_STATUS, 8'h01, 8'hFF);
      chk(irq, 1'b0);
      rd_reg(LINCSR_ADDR_CTRL, 8'h00, 8'h0C);
      wr_reg(LINCSR_ADDR_CTRL, 8'h90); chk({halt, ack}, 2'b00);
      mm = 1'b0; wr_reg(LINCSR_ADDR_CTRL, 8'h01); chk(go, 1'b0);
      $display("test master_frame done");
      @(negedge clk); fe = 5'h17;
      @(negedge clk); fe = 5'h00;
      rd_reg(LINCSR_ADDR_FAULT, 8'h17, 8'hFF);
      rd_reg(LINCSR_ADDR_STATUS, 8'h0C, 8'h0C);
      wr_reg(LINCSR_ADDR_CTRL, 8'h04); rd_reg(LINCSR_ADDR_FAULT, 8'h00, 8'hFF);
      rd_reg(LINCSR_ADDR_STATUS, 8'h08, 8'h0C);
      mm = 1'b1; @(negedge clk); fe = 5'h08;
      @(negedge clk); fe = 5'h00; mm = 1'b0;
      rd_reg(LINCSR_ADDR_FAULT, 8'h00, 8'hFF);
      pulse(7'h20); rd_reg(LINCSR_ADDR_FAULT, 8'h04, 8'h04);
      wr_reg(LINCSR_ADDR_CTRL, 8'h04); wr_reg(LINCSR_ADDR_CTRL, 8'h10); chk(ack, 1'b1);
      pulse(7'h20); rd_reg(LINCSR_ADDR_FAULT, 8'h00, 8'h04);
      pulse(7'h04); chk(ack, 1'b0);
      $display("test faults done");
      pulse(7'h02); wr_reg(LINCSR_ADDR_CTRL, 8'h80); chk(halt, 1'b1);
      rd_reg(LINCSR_ADDR_CTRL, 8'h00, 8'h80);
      rd_reg(LINCSR_ADDR_STATUS, 8'h20, 8'h20);
      pulse(7'h01); chk(halt, 1'b0);
      rd_reg(LINCSR_ADDR_STATUS, 8'h20, 8'h20);
      pulse(7'h04); pulse(7'h01); rd_reg(LINCSR_ADDR_STATUS, 8'h00, 8'h20);
      pulse(7'h08); rd_reg(LINCSR_ADDR_STATUS, 8'h10, 8'h10);
      wr_reg(LINCSR_ADDR_CTRL, 8'h02); chk(wtx, 1'b1);
      rd_reg(LINCSR_ADDR_STATUS, 8'h02, 8'h02);
      for (a = 0; a < 20 && wtx; a++) @(negedge clk);
      rd_reg(LINCSR_ADDR_CTRL, 8'h00, 8'h02);
      pulse(7'h10); rd_reg(LINCSR_ADDR_STATUS, 8'h0A, 8'h0A);
      wr_reg(LINCSR_ADDR_CTRL, 8'h40); chk(dorm, 1'b1);
      $display("test slave_controls done");
      wr_reg(LINCSR_ADDR_SIZE, 8'h85); chk({enh, len}, 5'h15);
      wr_reg(LINCSR_ADDR_SIZE, 8'h09); chk(lres, 1'b1);
      wr_reg(LINCSR_ADDR_SIZE, 8'h08); chk({lres, len}, 5'h08);
      wr_reg(LINCSR_ADDR_SIZE, 8'h0F);
      for (a = 0; a < 4; a++) begin
         @(negedge clk); tag = {a[1:0], 4'h0};
         @(negedge clk); chk(len, lut[a]);
      end
      wr_reg(LINCSR_ADDR_DIVLO, 8'hC7); wr_reg(LINCSR_ADDR_SCALE, 8'h00);
      chk({dok, div}, 10'h0C7);
      wr_reg(LINCSR_ADDR_DIVLO, 8'hC8); chk(dok, 1'b1);
      wr_reg(LINCSR_ADDR_SCALE, 8'hFF); chk({pre, mul, div}, 16'hC1C8);
      mm = 1'b1; @(negedge clk); chk(mul, 5'h1F);
      $display("test fields done");
      wrap_up();
   end

   // Watchdog: the whole run needs well under ten microseconds
   initial begin
      #50us;
      fail_count++;
      wrap_up();
   end
endmodule : lincsr_core_test

bind lincsr_core lincsr_core_asserts u_chk (.i_core_clk(i_core_clk), .i_rst(i_rst),
   .i_ptr(i_ptr), .i_win_wr(i_win_wr), .i_win_rd(i_win_rd), .i_win_wdata(i_win_wdata),
   .o_win_rdata(o_win_rdata), .i_master_mode(i_master_mode), .i_break_seen(i_break_seen),
   .i_frame_end(i_frame_end), .i_wake_sent(i_wake_sent), .i_fault_evt(i_fault_evt),
   .o_frame_go(o_frame_go), .o_wake_tx(o_wake_tx), .o_halted(o_halted), .o_tx_dir(o_tx_dir),
   .o_ack(o_ack), .o_divisor(o_divisor), .o_div_ok(o_div_ok), .o_irq(o_irq));
